// ===== rtl/rds_pkg.sv
// constants, types and frame layout shared by both ends of the relay driver serial link
//------------------------------------------------------------------------------
// Notes on behaviour
// - chip select high: ignore clock, input; output released
// - sample input on falling, shift on rising
// - input bits arrive most significant first
// - output bits most significant first, after rising
// - chip select fall loads diagnosis, or a pending read reply, into shifter
// - chip select fall drives error OR input
// - error indication holds until first rising clock
// - count clocks modulo eight, decode whole multiples
// - bad count sets error flag, drops command
// - chip select rise copies shifter to matrix
// - master keeps clock low at select edges
// - master ends every access raising select
// - frame is eight bits: control then data
// - one shifter, input in, output out, chainable
// - chained devices need N times eight clocks
// - enable bits switch channel diagnosis current
// - control bank: eight four-bit registers, 3-bit pointer
// - diagnosis bank: four four-bit registers, 2-bit pointer
// - reply bit marks register data versus diagnosis
// - reset restores interface and registers
// - diagnosis bank read only, bank select one
//------------------------------------------------------------------------------
package rds_pkg;
	// frame geometry
	localparam int FRAME_BITS = 8;
	localparam int CNT_W = 3;
	localparam int REG_W = 4;
	localparam int CTRL_PTR_W = 3;
	localparam int DIAG_PTR_W = 2;
	localparam int CTRL_REGS = 8;
	localparam int DIAG_REGS = 4;
	localparam int CHANNELS = 8;
	// frame field positions
	localparam int FR_WRITE_BIT = 7;
	localparam int FR_BANK_BIT = 6;
	localparam int FR_ADDR_HI = 6;
	localparam int FR_ADDR_LO = 4;
	localparam int FR_DATA_HI = 3;
	localparam logic BANK_DIAG = 1'b1;
	// control bank addresses of the diagnosis current enables
	localparam logic [2:0] ADDR_DCEN_LOW = 3'h4;
	localparam logic [2:0] ADDR_DCEN_HIGH = 3'h5;
	// values after reset
	localparam logic [3:0] CTRL_RESET = 4'h0;
	localparam logic [7:0] FRAME_RESET = 8'h00;
	localparam logic [2:0] CNT_RESET = 3'h0;
	// controller register offsets and fields
	localparam logic [7:0] HOST_TX_OFS = 8'h00;
	localparam logic [7:0] HOST_RX_OFS = 8'h04;
	localparam logic [7:0] HOST_STATUS_OFS = 8'h08;
	localparam int TX_LEN_LO = 8;
	localparam int TX_LEN_HI = 11;
	localparam logic [3:0] TX_LEN_DEFAULT = 4'h8;
	// serial clock half period in system clocks
	localparam int SCLK_HALF_CYCLES = 4;
	localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

	typedef enum logic [4:0] {
		H_IDLE = 5'h01,
		H_LEAD = 5'h02,
		H_HIGH = 5'h04,
		H_LOW = 5'h08,
		H_TAIL = 5'h10
	} rds_host_state_e;
endpackage

// ===== rtl/rds_if.sv
// serial link between controller and relay driver
`timescale 1ns/1ns
interface rds_if;
	logic master_select_line;
	logic sclk;
	logic master_out_line;
	logic so;
	logic so_oe_n;
	logic master_in_line;

	// released output reads low on the shared line
	assign master_in_line = so_oe_n ? 1'b0 : so;

	modport device (
		input master_select_line,
		input sclk,
		input master_out_line,
		output so,
		output so_oe_n
	);

	modport host (
		output master_select_line,
		output sclk,
		output master_out_line,
		input master_in_line
	);
endinterface

// ===== rtl/rds_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ns
module rds_sync #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// async in, synced out
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta;

	// first stage feeds only the second
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta <= '0;
			q <= '0;
		end else begin
			meta <= d;
			q <= meta;
		end
	end
endmodule

// ===== rtl/rds_device.sv
// relay driver serial slave: shifter, framing check, register banks
`timescale 1ns/1ns
module rds_device (
	// system
	input wire logic hclk,
	input wire logic hresetn,
	// serial link
	rds_if.device link,
	// diagnosis flags, per channel {open load, fault}, channel 0 lowest
	input wire logic [15:0] diag_flags,
	// outputs to the power stage
	output logic [7:0] diag_current_on,
	output logic framing_error_flag,
	output logic [7:0] in_matrix
);
	//--------------------------------------------------------------------
	// pin synchronisation and edge detection
	//--------------------------------------------------------------------
	logic cs_s;
	logic sclk_s;
	logic si_s;
	logic sel_s;
	logic cs_d;
	logic sclk_d;
	logic cs_fall;
	logic cs_rise;
	logic active;
	logic sclk_rise;
	logic sclk_fall;

	rds_sync #(
		.WIDTH(3)
	) u_sync (
		.clk(hclk),
		.rst_n(hresetn),
		.d({~link.master_select_line, link.sclk, link.master_out_line}),
		.q({sel_s, sclk_s, si_s})
	);

	// select synced true-high so its reset value means deselected, no false edge
	assign cs_s = ~sel_s;

	// delayed copies of the synced levels for edge finding
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cs_d <= 1'b1;
			sclk_d <= 1'b0;
		end else begin
			cs_d <= cs_s;
			sclk_d <= sclk_s;
		end
	end

	// clock edges count only while selected
	assign cs_fall = cs_d & ~cs_s;
	assign cs_rise = ~cs_d & cs_s;
	assign active = ~cs_s & ~cs_d;
	assign sclk_rise = active & ~sclk_d & sclk_s;
	assign sclk_fall = active & sclk_d & ~sclk_s;

	//--------------------------------------------------------------------
	// diagnosis summary and reply word
	//--------------------------------------------------------------------
	logic [rds_pkg::CHANNELS-1:0] chan_fault;
	logic reply_valid;
	logic [rds_pkg::CTRL_PTR_W-1:0] reply_ptr;
	logic reply_bank;
	logic [rds_pkg::REG_W-1:0] ctrl_bank [rds_pkg::CTRL_REGS];
	logic [rds_pkg::REG_W-1:0] diag_bank [rds_pkg::DIAG_REGS];
	logic [rds_pkg::REG_W-1:0] reply_data;
	logic [rds_pkg::FRAME_BITS-1:0] tx_word;

	// per channel: any latched fault or open load
	genvar ch;
	generate
		for (ch = 0; ch < rds_pkg::CHANNELS; ch++) begin : g_fault
			assign chan_fault[ch] = diag_flags[2*ch] | diag_flags[2*ch+1];
		end
	endgenerate

	// diagnosis bank is a read-only view of the flags
	genvar dr;
	generate
		for (dr = 0; dr < rds_pkg::DIAG_REGS; dr++) begin : g_diag
			assign diag_bank[dr] = diag_flags[4*dr +: 4];
		end
	endgenerate

	// bank select one reaches the diagnosis bank
	always_comb begin
		if (reply_bank == rds_pkg::BANK_DIAG) begin
			reply_data = diag_bank[reply_ptr[rds_pkg::DIAG_PTR_W-1:0]];
		end else begin
			reply_data = ctrl_bank[reply_ptr];
		end
	end

	// top bit tells register contents from standard diagnosis
	always_comb begin
		if (reply_valid) begin
			tx_word = {1'b1, reply_ptr, reply_data};
		end else begin
			tx_word = {1'b0, chan_fault[7] | chan_fault[6], chan_fault[5:0]};
		end
	end

	//--------------------------------------------------------------------
	// shift register and serial output
	//--------------------------------------------------------------------
	logic [rds_pkg::FRAME_BITS-1:0] shifter;
	logic before_first_rise;

	// one shifter: loaded at select fall, input in at falling clock
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			shifter <= rds_pkg::FRAME_RESET;
		end else if (cs_fall) begin
			shifter <= tx_word;
		end else if (sclk_fall) begin
			shifter <= {shifter[rds_pkg::FRAME_BITS-2:0], si_s};
		end
	end

	// error indication window lasts up to the first rising clock
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			before_first_rise <= 1'b0;
		end else if (cs_fall) begin
			before_first_rise <= 1'b1;
		end else if (sclk_rise || cs_rise) begin
			before_first_rise <= 1'b0;
		end
	end

	// output drive: released while deselected, msb out on rising clock
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			link.so <= 1'b0;
			link.so_oe_n <= 1'b1;
		end else if (cs_rise) begin
			link.so <= 1'b0;
			link.so_oe_n <= 1'b1;
		end else if (cs_fall) begin
			link.so <= framing_error_flag | si_s;
			link.so_oe_n <= 1'b0;
		end else if (sclk_rise) begin
			link.so <= shifter[rds_pkg::FRAME_BITS-1];
		end else if (before_first_rise && active) begin
			link.so <= framing_error_flag | si_s;
		end
	end

	//--------------------------------------------------------------------
	// clock counting and framing check
	//--------------------------------------------------------------------
	logic [rds_pkg::CNT_W-1:0] clk_count;
	logic any_clock;
	logic frame_ok;

	// modulo eight count of falling clocks, cleared per access
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			clk_count <= rds_pkg::CNT_RESET;
			any_clock <= 1'b0;
		end else if (cs_fall) begin
			clk_count <= rds_pkg::CNT_RESET;
			any_clock <= 1'b0;
		end else if (sclk_fall) begin
			clk_count <= clk_count + 3'h1;
			any_clock <= 1'b1;
		end
	end

	// whole nonzero multiple of eight clocks, daisy chains included
	assign frame_ok = any_clock && (clk_count == rds_pkg::CNT_RESET);

	// flag set by a bad frame, cleared by the next good one
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			framing_error_flag <= 1'b0;
		end else if (cs_rise && !frame_ok) begin
			framing_error_flag <= 1'b1;
		end else if (cs_rise) begin
			framing_error_flag <= 1'b0;
		end
	end

	// shifter always lands in the matrix register at select rise
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			in_matrix <= rds_pkg::FRAME_RESET;
		end else if (cs_rise) begin
			in_matrix <= shifter;
		end
	end

	//--------------------------------------------------------------------
	// command decoding and control bank
	//--------------------------------------------------------------------
	// frame: write bit, then address or bank bit, then data or, for reads, pointer in the low bits
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int i = 0; i < rds_pkg::CTRL_REGS; i++) begin
				ctrl_bank[i] <= rds_pkg::CTRL_RESET;
			end
		end else if (cs_rise && frame_ok && shifter[rds_pkg::FR_WRITE_BIT]) begin
			ctrl_bank[shifter[rds_pkg::FR_ADDR_HI:rds_pkg::FR_ADDR_LO]]
				<= shifter[rds_pkg::FR_DATA_HI:0];
		end
	end

	// read request answered in the next frame only; bad frames drop it
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			reply_valid <= 1'b0;
			reply_bank <= 1'b0;
			reply_ptr <= 3'h0;
		end else if (cs_rise) begin
			reply_valid <= frame_ok && !shifter[rds_pkg::FR_WRITE_BIT];
			reply_bank <= shifter[rds_pkg::FR_BANK_BIT];
			reply_ptr <= shifter[rds_pkg::CTRL_PTR_W-1:0];
		end
	end

	// per channel diagnosis current enables
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			diag_current_on <= {rds_pkg::CTRL_RESET, rds_pkg::CTRL_RESET};
		end else begin
			diag_current_on <= {ctrl_bank[rds_pkg::ADDR_DCEN_HIGH],
				ctrl_bank[rds_pkg::ADDR_DCEN_LOW]};
		end
	end
endmodule

// ===== rtl/rds_host.sv
// serial link controller with an AHB-Lite register slave
`timescale 1ns/1ns
module rds_host #(
	parameter int HALF_CYCLES = rds_pkg::SCLK_HALF_CYCLES
) (
	// system
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// serial link
	rds_if.host link
);
	//--------------------------------------------------------------------
	// bus slave
	//--------------------------------------------------------------------
	logic accept;
	logic wr_pend;
	logic [7:0] wr_ofs;
	logic start;
	logic busy;
	logic [3:0] tx_len;
	logic [rds_pkg::FRAME_BITS-1:0] rx_byte;

	// whole-word single transfers only; other sizes are not taken
	assign accept = hsel && htrans[1] && hready && (hsize == 3'h2);

	// address phase remembered for the write data that follows
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend <= 1'b0;
			wr_ofs <= 8'h00;
		end else if (accept) begin
			wr_pend <= hwrite;
			wr_ofs <= haddr[7:0];
		end else if (hready) begin
			wr_pend <= 1'b0;
		end
	end

	// no wait states and always okay; a busy link drops the new frame instead
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	// read data fetched in the address phase, standing through the data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= rds_pkg::ZERO_WORD;
		end else if (accept && !hwrite) begin
			case (haddr[7:0])
				rds_pkg::HOST_RX_OFS: begin
					hrdata <= {24'h00_0000, rx_byte};
				end
				rds_pkg::HOST_STATUS_OFS: begin
					hrdata <= {31'h0000_0000, busy};
				end
				default: begin
					hrdata <= rds_pkg::ZERO_WORD;
				end
			endcase
		end
	end

	// a write of the transmit word starts a frame only when the link is free
	assign start = wr_pend && hready && (wr_ofs == rds_pkg::HOST_TX_OFS) && !busy;
	// zero length means one plain frame; a chain needs eight per device
	assign tx_len = (hwdata[rds_pkg::TX_LEN_HI:rds_pkg::TX_LEN_LO] == 4'h0) ?
		rds_pkg::TX_LEN_DEFAULT : hwdata[rds_pkg::TX_LEN_HI:rds_pkg::TX_LEN_LO];

	//--------------------------------------------------------------------
	// half-period divider
	//--------------------------------------------------------------------
	localparam int DIV_W = $clog2(HALF_CYCLES) + 1;
	localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(HALF_CYCLES - 1);
	logic [DIV_W-1:0] div_cnt;
	logic tick;
	rds_pkg::rds_host_state_e state;

	assign busy = (state != rds_pkg::H_IDLE);
	assign tick = busy && (div_cnt == DIV_LAST);

	// parked while idle, so every frame starts on a fresh half period
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			div_cnt <= '0;
		end else if (!busy || tick) begin
			div_cnt <= '0;
		end else begin
			div_cnt <= div_cnt + 1'b1;
		end
	end

	//--------------------------------------------------------------------
	// frame sequencing
	//--------------------------------------------------------------------
	logic [3:0] bits_left;
	logic rise_now;
	logic fall_now;
	logic last_now;
	logic end_now;
	logic [rds_pkg::FRAME_BITS-1:0] tx_shift;
	logic mi_s;

	// clock edges and frame end, one enable pulse each
	assign rise_now = tick && ((state == rds_pkg::H_LEAD) ||
		((state == rds_pkg::H_LOW) && (bits_left != 4'h0)));
	assign fall_now = tick && (state == rds_pkg::H_HIGH);
	assign last_now = tick && (state == rds_pkg::H_LOW) && (bits_left == 4'h0);
	assign end_now = tick && (state == rds_pkg::H_TAIL);

	// lead, one high and one low half period per bit, then a tail
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state <= rds_pkg::H_IDLE;
		end else begin
			case (state)
				rds_pkg::H_IDLE: begin
					if (start) begin
						state <= rds_pkg::H_LEAD;
					end
				end
				rds_pkg::H_LEAD: begin
					if (rise_now) begin
						state <= rds_pkg::H_HIGH;
					end
				end
				rds_pkg::H_HIGH: begin
					if (fall_now) begin
						state <= rds_pkg::H_LOW;
					end
				end
				rds_pkg::H_LOW: begin
					if (rise_now) begin
						state <= rds_pkg::H_HIGH;
					end else if (last_now) begin
						state <= rds_pkg::H_TAIL;
					end
				end
				rds_pkg::H_TAIL: begin
					if (end_now) begin
						state <= rds_pkg::H_IDLE;
					end
				end
				default: begin
					state <= rds_pkg::H_IDLE;
				end
			endcase
		end
	end

	// select moves only while the clock is parked low
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			link.master_select_line <= 1'b1;
		end else if (start) begin
			link.master_select_line <= 1'b0;
		end else if (end_now) begin
			link.master_select_line <= 1'b1;
		end
	end

	// serial clock: low at rest, high for one half period per bit
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			link.sclk <= 1'b0;
		end else if (rise_now) begin
			link.sclk <= 1'b1;
		end else if (fall_now) begin
			link.sclk <= 1'b0;
		end
	end

	// transmit shifter moves on the fall, before the device samples; the line holds until the next rise
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tx_shift <= rds_pkg::FRAME_RESET;
			bits_left <= '0;
		end else if (start) begin
			tx_shift <= hwdata[rds_pkg::FRAME_BITS-1:0];
			bits_left <= tx_len;
		end else if (fall_now) begin
			tx_shift <= {tx_shift[rds_pkg::FRAME_BITS-2:0], 1'b0};
			bits_left <= bits_left - 4'h1;
		end
	end

	// output bit changes on the rise, a half period clear of the sampling fall
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			link.master_out_line <= 1'b0;
		end else if (start) begin
			link.master_out_line <= hwdata[rds_pkg::FRAME_BITS-1];
		end else if (rise_now) begin
			link.master_out_line <= tx_shift[rds_pkg::FRAME_BITS-1];
		end
	end

	// returned line passes two flip-flops before use
	rds_sync #(
		.WIDTH(1)
	) u_sync_mi (
		.clk(hclk),
		.rst_n(hresetn),
		.d(link.master_in_line),
		.q(mi_s)
	);

	// sampled a full period late, since the synchroniser would miss the fall;
	// the first sample is the released low line, ahead of the error indication, and drops off the top
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_byte <= rds_pkg::FRAME_RESET;
		end else if (rise_now || last_now) begin
			rx_byte <= {rx_byte[rds_pkg::FRAME_BITS-2:0], mi_s};
		end
	end
endmodule

// ===== tb/rds_link_sva.sv
// concurrent checks on the serial link between controller and device
`timescale 1ns/1ns
module rds_link_sva (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// link lines
	input wire logic master_select_line,
	input wire logic sclk,
	input wire logic master_out_line,
	input wire logic so,
	input wire logic so_oe_n,
	// device status
	input wire logic framing_error_flag
);
	localparam int SYNC_MAX = 6;
	localparam int FRAME_MAX = 400;
	logic [9:0] sel_cnt;
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// cycles spent selected; catches a frame that never ends
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			sel_cnt <= 10'h000;
		else
			sel_cnt <= master_select_line ? 10'h000 : sel_cnt + 10'h001;
	end
	//----------------
	// link checks
	//----------------
	chk_release_on_deselect: assert property ($rose(master_select_line) |-> ##[1:SYNC_MAX] so_oe_n)
		else $error("output not released after deselect");
	chk_idle_released: assert property (master_select_line [*8] |-> so_oe_n)
		else $error("output driven while deselected");
	chk_drive_on_select: assert property ($fell(master_select_line) |-> ##[1:SYNC_MAX] !so_oe_n)
		else $error("output not driven after select");
	chk_first_bit_value: assert property ($fell(so_oe_n) |-> so == (framing_error_flag | master_out_line))
		else $error("first output level not error or input");
	chk_sclk_low_edges: assert property ($changed(master_select_line) |-> !sclk)
		else $error("clock high at select change");
	chk_lead_time: assert property ($fell(master_select_line) |=> !sclk [*2])
		else $error("clock moved right after select");
	chk_clock_in_frame: assert property ($changed(sclk) |-> !master_select_line)
		else $error("clock toggled outside frame");
	chk_frame_ends: assert property (sel_cnt < FRAME_MAX)
		else $error("select held low too long");
endmodule

// ===== tb/relay_driver_spi_slave_tb.sv
// self-checking bench: controller and device joined over the serial link
`timescale 1ns/1ns
module relay_driver_spi_slave_tb;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0000_0000;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0000_0000;
	logic [31:0] hrdata;
	logic hreadyout;
	logic hresp;
	logic rresp;
	logic [31:0] rdata;
	logic [15:0] diag_flags = 16'h00a5;
	logic [7:0] diag_current_on;
	logic framing_error_flag;
	logic [7:0] in_matrix;
	int n_errors = 0;
	int cmp_count = 0;
	int cycles = 0;
	rds_if lnk();
	rds_host i_rds_host (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .link(lnk));
	rds_device i_rds_device (.hclk(hclk), .hresetn(hresetn), .link(lnk), .diag_flags(diag_flags),
		.diag_current_on(diag_current_on), .framing_error_flag(framing_error_flag),
		.in_matrix(in_matrix));
	rds_link_sva i_rds_link_sva (.hclk(hclk), .hresetn(hresetn),
		.master_select_line(lnk.master_select_line), .sclk(lnk.sclk),
		.master_out_line(lnk.master_out_line), .so(lnk.so), .so_oe_n(lnk.so_oe_n),
		.framing_error_flag(framing_error_flag));
	// clock
	always #2 hclk = ~hclk;
	// hang guard, generous for eight short frames
	always @(posedge hclk) begin
		cycles++;
		if (cycles == 20000) begin
			n_errors++;
			final_report();
		end
	end
	//----------------
	// helpers
	//----------------
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	// one single-word transfer; waits on the slave, not on a count
	task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= wr;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rresp = hresp;
		rdata = hrdata;
	endtask
	// send one frame of len clocks and let the device settle
	task automatic frame(input logic [3:0] len, input logic [7:0] data);
		ahb(1'b1, {24'h0, rds_pkg::HOST_TX_OFS}, {20'h0, len, data});
		wait (lnk.master_select_line === 1'b0);
		wait (lnk.master_select_line === 1'b1);
		repeat (8) @(posedge hclk);
	endtask
	task automatic final_report();
		if (n_errors == 0 && cmp_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	//----------------
	// scenarios
	//----------------
	task automatic t_reset_values();
		chk("enables", 8'h00, diag_current_on);
		chk("error", 1'b0, framing_error_flag);
		chk("matrix", 8'h00, in_matrix);
		ahb(1'b0, 32'h0000_0010, 32'h0);
		chk("hresp", 1'b0, rresp);
	endtask
	task automatic t_write_low();
		frame(4'h8, 8'hca);
		chk("matrix", 8'hca, in_matrix);
		chk("enables", 8'h0a, diag_current_on);
		ahb(1'b0, {24'h0, rds_pkg::HOST_RX_OFS}, 32'h0);
		chk("rx", 8'h0f, rdata);
	endtask
	// read requests answered in the next frame, control then diagnosis bank
	task automatic t_read_back();
		frame(4'h8, 8'h05);
		frame(4'h8, 8'h41);
		ahb(1'b0, {24'h0, rds_pkg::HOST_RX_OFS}, 32'h0);
		chk("rx", 8'hd5, rdata);
		frame(4'h8, 8'h00);
		ahb(1'b0, {24'h0, rds_pkg::HOST_RX_OFS}, 32'h0);
		chk("rx", 8'h9a, rdata);
		chk("enables", 8'h5a, diag_current_on);
	endtask
	task automatic t_write_high();
		frame(4'h8, 8'hd5);
		chk("enables", 8'h5a, diag_current_on);
	endtask
	// seven clocks only: command must be dropped
	task automatic t_bad_count();
		frame(4'h7, 8'hc0);
		chk("error", 1'b1, framing_error_flag);
		chk("enables", 8'h5a, diag_current_on);
	endtask
	// next good frame judged on its own count
	task automatic t_recover();
		frame(4'h8, 8'hc3);
		chk("enables", 8'h53, diag_current_on);
	endtask
	task automatic t_mid_reset();
		@(posedge hclk);
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		chk("enables", 8'h00, diag_current_on);
		chk("matrix", 8'h00, in_matrix);
		chk("release", 1'b1, lnk.so_oe_n);
		hresetn <= 1'b1;
		frame(4'h8, 8'hd9);
		chk("enables", 8'h90, diag_current_on);
	endtask
	// main sequence
	initial begin
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		t_reset_values();
		t_write_low();
		t_write_high();
		t_read_back();
		t_bad_count();
		t_recover();
		t_mid_reset();
		final_report();
	end
endmodule
